/* File: hdl/clock_gear_prescaler_control.v */
`timescale 1ns/1ns
`include "clock_gear_map.vh"
module clock_gear_prescaler_control (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // avalon-mm slave
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  // oscillator ticks from outside domains
  input wire high_osc_tick,
  input wire low_osc_tick,
  input wire low_speed_clock,
  // clock enables out
  output reg gear_tick,
  output reg periph_tick,
  output reg prescaler_tick,
  output reg clock_out_pin,
  // oscillator and mode control
  output reg high_osc_enable,
  output reg low_osc_enable,
  output reg pll_run,
  output reg warmup_busy_flag,
  output reg [2:0] low_power_mode,
  output reg mode_request,
  // interrupt
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers

  reg [2:0] hs_sync_reg;
  reg [2:0] ls_sync_reg;
  reg [1:0] lsc_sync_reg;
  wire hs_tick;
  wire ls_tick;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hs_sync_reg <= 3'h0;
      ls_sync_reg <= 3'h0;
      lsc_sync_reg <= 2'h0;
    end else begin
      hs_sync_reg <= {hs_sync_reg[1:0], high_osc_tick};
      ls_sync_reg <= {ls_sync_reg[1:0], low_osc_tick};
      lsc_sync_reg <= {lsc_sync_reg[0], low_speed_clock};
    end
  end

  // rising edges after two stages
  assign hs_tick = hs_sync_reg[1] & ~hs_sync_reg[2];
  assign ls_tick = ls_sync_reg[1] & ~ls_sync_reg[2];

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg [31:0] sys_reg;
  reg [31:0] osc_reg;
  reg [31:0] stby_reg;
  reg [31:0] pllsel_reg;
  reg [31:0] cksel_reg;
  reg [`IRQ_BITS-1:0] status_reg;
  reg [`IRQ_BITS-1:0] mask_reg;
  reg pending_reg;
  reg start_reg;
  reg busy_seen_reg;
  wire warm_busy;
  wire warm_done;
  wire [31:0] be_mask;
  wire wr_go;
  wire rd_go;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [31:0] lanes;
    input [31:0] field;
    begin
      merge = (old & ~(lanes & field)) | (data & lanes & field);
    end
  endfunction

  function [4:0] warm_exp;
    input [2:0] code;
    input low;
    begin
      if (code == 3'h0)
        warm_exp = 5'd0;
      else if (!low)
        warm_exp = 5'd9 + {2'b00, code};
      else if (code <= 3'h3)
        warm_exp = 5'd5 + {2'b00, code};
      else
        warm_exp = 5'd11 + {2'b00, code};
    end
  endfunction

  assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
  // one wait cycle: writes land on the second edge, read data loads on the first
  // so that it stands at the edge where waitrequest is sampled low
  assign wr_go = write & pending_reg;
  assign rd_go = read & ~pending_reg;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_reg <= `SYS_RESET;
      osc_reg <= `OSC_RESET;
      stby_reg <= `STBY_RESET;
      pllsel_reg <= `PLLSEL_RESET;
      cksel_reg <= `CKSEL_RESET;
      mask_reg <= {`IRQ_BITS{1'b0}};
      start_reg <= 1'b0;
      pending_reg <= 1'b0;
      mode_request <= 1'b0;
      readdata <= 32'h00000000;
      waitrequest <= 1'b1;
    end else begin
      start_reg <= 1'b0;
      mode_request <= 1'b0;
      pending_reg <= (read | write) & ~pending_reg;
      waitrequest <= ~((read | write) & ~pending_reg);
      if (wr_go) begin
        case (address) // RULE_05
          `OFS_SYSCTL:
            sys_reg <= merge(sys_reg, writedata, be_mask, `SYS_MASK); // RULE_11
          `OFS_OSCCTL: begin
            osc_reg <= merge(osc_reg, writedata, be_mask, `OSC_MASK);
            if (byteenable[0] && writedata[`OSC_START_BIT])
              start_reg <= 1'b1; // RULE_07
          end
          `OFS_STBYCTL: begin
            stby_reg <= merge(stby_reg, writedata, be_mask, `STBY_MASK);
            if (byteenable[0])
              mode_request <= 1'b1; // RULE_06
          end
          `OFS_PLLSEL:
            pllsel_reg <= merge(pllsel_reg, writedata, be_mask, `PLLSEL_MASK);
          `OFS_CKSEL:
            cksel_reg <= merge(cksel_reg, writedata, be_mask, `CKSEL_MASK);
          `OFS_IRQ_MASK:
            mask_reg <= writedata[`IRQ_BITS-1:0];
          default: ;
        endcase
      end
      if (rd_go) begin
        case (address)
          `OFS_SYSCTL: readdata <= sys_reg & `SYS_MASK; // RULE_11
          `OFS_OSCCTL: readdata <= (osc_reg & `OSC_MASK) | {30'h0, warm_busy, 1'b0}; // RULE_08
          `OFS_STBYCTL: readdata <= stby_reg & `STBY_MASK;
          `OFS_PLLSEL: readdata <= pllsel_reg & `PLLSEL_MASK;
          `OFS_CKSEL: readdata <= cksel_reg & `CKSEL_MASK;
          `OFS_IRQ_STATUS: readdata <= {{(32-`IRQ_BITS){1'b0}}, status_reg};
          `OFS_IRQ_MASK: readdata <= {{(32-`IRQ_BITS){1'b0}}, mask_reg};
          default: readdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, set wins over clear

  wire [`IRQ_BITS-1:0] ev;
  wire [`IRQ_BITS-1:0] clr;
  wire stby_valid;

  assign stby_valid = (stby_reg[2:0] == `MODE_STOP) || (stby_reg[2:0] == `MODE_SLEEP) ||
                      (stby_reg[2:0] == `MODE_IDLE);
  assign ev = {mode_request & stby_valid, warm_done};
  assign clr = (wr_go && address == `OFS_IRQ_STATUS && byteenable[0]) ?
               writedata[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= {`IRQ_BITS{1'b0}};
      irq <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~clr) | ev;
      irq <= |(((status_reg & ~clr) | ev) & mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // warm-up

  warmup_timer warm_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(start_reg), // RULE_07
    .osc_tick(osc_reg[`OSC_WSRC_BIT] ? ls_tick : hs_tick), // RULE_09
    .exponent(warm_exp(osc_reg[6:4], osc_reg[`OSC_WSRC_BIT])), // RULE_09
    .busy(warm_busy),
    .done(warm_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock chain

  reg [2:0] gear_shift;
  reg [2:0] pre_shift;
  wire gear_t;
  wire pre_t;
  wire sys_half;
  wire periph_t;

  always @* begin
    case (sys_reg[2:0]) // RULE_04
      3'h4: gear_shift = 3'h1;
      3'h5: gear_shift = 3'h2;
      3'h6: gear_shift = 3'h3;
      default: gear_shift = 3'h0;
    endcase
    case (sys_reg[10:8]) // RULE_03
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5: pre_shift = sys_reg[10:8];
      default: pre_shift = 3'h0;
    endcase
  end

  clock_divider #(.CW(5)) gear_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick_in(1'b1),
    .shift(gear_shift),
    .tick_out(gear_t),
    .half_out(sys_half)
  );

  assign periph_t = sys_reg[`SYS_PERIPH_SOURCE_SELECT_BIT] ? 1'b1 : gear_t; // RULE_02

  clock_divider #(.CW(5)) pre_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick_in(periph_t),
    .shift(pre_shift),
    .tick_out(pre_t),
    .half_out()
  );

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gear_tick <= 1'b0;
      periph_tick <= 1'b0;
      prescaler_tick <= 1'b0;
      clock_out_pin <= 1'b0;
      high_osc_enable <= 1'b1;
      low_osc_enable <= 1'b1;
      pll_run <= 1'b0;
      warmup_busy_flag <= 1'b0;
      low_power_mode <= 3'h0;
    end else begin
      gear_tick <= gear_t;
      periph_tick <= periph_t;
      prescaler_tick <= pre_t;
      case (sys_reg[17:16]) // RULE_01
        2'h0: clock_out_pin <= lsc_sync_reg[1];
        2'h1: clock_out_pin <= sys_half;
        2'h2: clock_out_pin <= gear_t;
        default: clock_out_pin <= pre_t;
      endcase
      high_osc_enable <= osc_reg[`OSC_HEN_BIT];
      low_osc_enable <= osc_reg[`OSC_LEN_BIT];
      pll_run <= osc_reg[`OSC_PLL_BIT]; // RULE_10
      warmup_busy_flag <= warm_busy; // RULE_08
      low_power_mode <= stby_valid ? stby_reg[2:0] : 3'h0; // RULE_06
    end
  end

endmodule // clock_gear_prescaler_control

/* File: hdl/clock_gear_map.vh */
// Contract
// RULE_01: The clock output pin carries the low-speed clock, the system clock halved, the system clock or the prescaler clock for select codes 00, 01, 10 and 11, and the select resets to 01.
// RULE_02: The peripheral clock comes from the geared clock when the source select is 0 and from the undivided high-speed clock when it is 1, and the select resets to 0.
// RULE_03: The prescaler clock is the peripheral clock divided by 1, 2, 4, 8, 16 or 32 for codes 000 to 101, and codes 110 and 111 are reserved.
// RULE_04: The geared clock is the high-speed clock undivided for 000 and divided by 2, 4 or 8 for 100, 101 and 110, other codes are reserved, and the gear resets to 000.
// RULE_05: The five control registers sit at byte offsets 0x0000 to 0x0010 in the order system control, oscillation, standby, PLL selection, system clock selection.
// RULE_06: Three low power modes exist besides normal mode and are entered through this block.
// RULE_07: Writing 1 to the warm-up start bit starts the warm-up timer, writing 0 does nothing, and the bit is never stored.
// RULE_08: The warm-up busy flag reads 1 while the warm-up count runs and 0 once it has completed.
// RULE_09: Warm-up counts clocks of the oscillator picked by the source select, 2^10 to 2^16 for high speed or 2^6 to 2^18 for low speed, per the time code.
// RULE_10: The PLL runs only while the PLL run bit is 1, and that bit is 0 after reset.
// RULE_11: Unused bits of the system control register read as zero and writes to them have no effect.
`ifndef CLOCK_GEAR_MAP_VH
`define CLOCK_GEAR_MAP_VH

// register byte offsets
`define OFS_SYSCTL 8'h00
`define OFS_OSCCTL 8'h04
`define OFS_STBYCTL 8'h08
`define OFS_PLLSEL 8'h0C
`define OFS_CKSEL 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18

// system control fields
`define SYS_GEAR_LSB 0
`define SYS_PRESCALER_RATIO_LSB 8
`define SYS_PERIPH_SOURCE_SELECT_BIT 12
`define SYS_CLKOUT_LSB 16
`define SYS_RESET 32'h00010000
`define SYS_MASK 32'h00031707

// oscillator control fields
`define OSC_START_BIT 0
`define OSC_BUSY_BIT 1
`define OSC_PLL_BIT 2
`define OSC_WSRC_BIT 3
`define OSC_WTIME_LSB 4
`define OSC_HEN_BIT 8
`define OSC_LEN_BIT 9
`define OSC_RESET 32'h00000310
`define OSC_MASK 32'h0000337C

// standby control
`define STBY_RESET 32'h00000103
`define STBY_MASK 32'h00030307
`define MODE_STOP 3'h1
`define MODE_SLEEP 3'h2
`define MODE_IDLE 3'h3

// selection registers
`define PLLSEL_RESET 32'h00000000
`define PLLSEL_MASK 32'h00000001
`define CKSEL_RESET 32'h00000000
`define CKSEL_MASK 32'h00000003

// interrupt status bits
`define IRQ_WARMUP_DONE 0
`define IRQ_MODE_REQ 1
`define IRQ_BITS 2

`endif

/* File: hdl/clock_divider.v */
`timescale 1ns/1ns
// divide-by-power-of-two pulse-enable generator
module clock_divider #(
  parameter CW = 5
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // control
  input wire tick_in,
  input wire [2:0] shift,
  // output
  output reg tick_out,
  output reg half_out
);

  reg [CW-1:0] count_reg;
  wire [CW-1:0] limit;

  assign limit = (shift == 3'h0) ? {CW{1'b0}} : ((({{(CW-1){1'b0}}, 1'b1}) << shift) - 1'b1);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= {CW{1'b0}};
      tick_out <= 1'b0;
      half_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (count_reg >= limit) begin
          count_reg <= {CW{1'b0}};
          tick_out <= 1'b1;
          half_out <= ~half_out;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end

endmodule // clock_divider

/* File: hdl/warmup_timer.v */
`timescale 1ns/1ns
// warm-up counter driven by oscillator ticks
module warmup_timer (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // control
  input wire start,
  input wire osc_tick,
  input wire [4:0] exponent,
  // status
  output reg busy,
  output reg done
);

  reg [18:0] count_reg;
  wire [18:0] target;

  assign target = (19'h00001 << exponent) - 19'h00001;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= 19'h00000;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_reg <= 19'h00000;
        busy <= (exponent != 5'h00);
        done <= (exponent == 5'h00);
      end else if (busy && osc_tick) begin
        if (count_reg == target) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_reg <= count_reg + 19'h00001;
        end
      end
    end
  end

endmodule // warmup_timer

/* File: bench/clock_gear_prescaler_control_properties.sv */
`timescale 1ns/1ns
module cg_props (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // bus
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] readdata,
  input wire waitrequest,
  // control
  input wire pll_run,
  input wire warmup_busy_flag,
  input wire mode_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire osc_wr = write && address == 8'h04;
  wire stby_wr = write && address == 8'h08;
  one_wait_a: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("no single wait state");
  wait_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  rdata_hold_a: assert property (!read && !$past(read) |-> $stable(readdata))
    else $error("readdata moved");
  pll_reset_a: assert property ($fell(sys_rst) |-> !pll_run)
    else $error("pll runs after reset");
  pll_cause_a: assert property ($changed(pll_run) |-> $past(osc_wr) || $past(osc_wr, 2))
    else $error("pll changed without write");
  warm_cause_a: assert property ($rose(warmup_busy_flag) |->
    $past(osc_wr) || $past(osc_wr, 2) || $past(osc_wr, 3) || $past(osc_wr, 4))
    else $error("warm-up began without write");
  mode_cause_a: assert property (mode_request |-> $past(stby_wr) || $past(stby_wr, 2))
    else $error("mode request without write");
  mode_pulse_a: assert property (mode_request |=> !mode_request)
    else $error("mode request too long");
endmodule // cg_props
////////////////////////////////////////
bind clock_gear_prescaler_control cg_props props (.clk(clk), .sys_rst(sys_rst),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .pll_run(pll_run), .warmup_busy_flag(warmup_busy_flag),
  .mode_request(mode_request));

/* File: bench/tb.sv */
`timescale 1ns/1ns
module tb;
  reg clk, sys_rst, read, write, high_osc_tick, low_osc_tick, low_speed_clock, osc_run;
  reg [7:0] address;
  reg [31:0] writedata, rdata;
  reg [3:0] byteenable;
  wire [31:0] readdata;
  wire waitrequest, gear_tick, periph_tick, prescaler_tick, clock_out_pin, high_osc_enable;
  wire low_osc_enable, pll_run, warmup_busy_flag, mode_request, irq;
  wire [2:0] low_power_mode;
  wire [3:0] outs = {clock_out_pin, prescaler_tick, periph_tick, gear_tick};
  integer n_fail, comparisons, cyc, i, n;
  clock_gear_prescaler_control dut (.clk(clk), .sys_rst(sys_rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .high_osc_tick(high_osc_tick),
    .low_osc_tick(low_osc_tick), .low_speed_clock(low_speed_clock), .gear_tick(gear_tick),
    .periph_tick(periph_tick), .prescaler_tick(prescaler_tick), .clock_out_pin(clock_out_pin),
    .high_osc_enable(high_osc_enable), .low_osc_enable(low_osc_enable), .pll_run(pll_run),
    .warmup_busy_flag(warmup_busy_flag), .low_power_mode(low_power_mode),
    .mode_request(mode_request), .irq(irq));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (osc_run) begin
      high_osc_tick <= ~high_osc_tick;
      low_osc_tick <= ~low_osc_tick;
    end
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  ////////////////////////////////////////
  task results;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d, input [3:0] be);
    begin
      address <= a;
      writedata <= d;
      byteenable <= be;
      write <= w;
      read <= !w;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      rdata = readdata;
      read <= 0;
      write <= 0;
      @(posedge clk);
    end
  endtask
  // reserved bits random, must not matter
  task wsys(input [2:0] g, input [2:0] p, input f, input [1:0] s);
    bus(1, 8'h00, ($urandom & ~32'h00031707) | {14'h0, s, 3'h0, f, 1'h0, p, 5'h0, g}, 4'hF);
  endtask
  // high cycles of one output over 64 cycles, after settling
  task cnt(input [1:0] s, input [31:0] e);
    begin
      repeat (40) @(posedge clk);
      n = 0;
      repeat (64) begin
        @(posedge clk);
        n = n + outs[s];
      end
      chk("tick count", e, n);
    end
  endtask
  task warm(input src, input [2:0] t, input [31:0] ticks);
    begin
      osc_run <= 1;
      bus(1, 8'h04, {22'h0, 2'h3, 1'h0, t, src, 3'h1}, 4'hF);
      repeat (2 * ticks - 8) @(posedge clk);
      chk("warm busy", 1, warmup_busy_flag);
      repeat (24) @(posedge clk);
      chk("warm done", 0, warmup_busy_flag);
      osc_run <= 0;
    end
  endtask
  function [31:0] rst_val(input integer k);
    case (k)
      0: rst_val = 32'h00010000;
      1: rst_val = 32'h00000310;
      2: rst_val = 32'h00000103;
      default: rst_val = 32'h0;
    endcase
  endfunction
  ////////////////////////////////////////
  initial begin
    {sys_rst, read, write, osc_run, high_osc_tick, low_osc_tick, low_speed_clock} = 7'h40;
    address = 0;
    writedata = 0;
    byteenable = 0;
    n_fail = 0;
    comparisons = 0;
    cyc = 0;
    i = $urandom(32519);
    repeat (4) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    bus(1, 8'h1C, 32'hFFFFFFFF, 4'hF);
    for (i = 0; i < 8; i = i + 1) begin
      bus(0, {i[5:0], 2'h0}, 0, 4'hF);
      chk("reset value", rst_val(i), rdata);
    end
    bus(1, 8'h00, 32'hFFFFFFFF, 4'hF);
    bus(0, 8'h00, 0, 4'hF);
    chk("sysctl bits", 32'h00031707, rdata);
    bus(1, 8'h00, 0, 4'h2);
    bus(0, 8'h00, 0, 4'hF);
    chk("lane merge", 32'h00030007, rdata);
    for (i = 0; i < 4; i = i + 1) begin
      wsys(i ? i + 3 : 0, 0, 0, 2'h2);
      cnt(0, 64 >> i);
      cnt(1, 64 >> i);
      cnt(3, 64 >> i);
    end
    wsys(6, 0, 1, 2'h1);
    cnt(1, 64);
    cnt(3, 32);
    for (i = 0; i < 8; i = i + 1) begin
      wsys(6, i, 1, 2'h3);
      cnt(2, i > 5 ? 64 : 64 >> i);
      cnt(3, i > 5 ? 64 : 64 >> i);
    end
    low_speed_clock <= 1;
    wsys(0, 0, 0, 2'h0);
    cnt(3, 64);
    bus(1, 8'h04, 32'h00000300, 4'hF);
    repeat (8) @(posedge clk);
    chk("no start", 0, warmup_busy_flag);
    warm(0, 3'h1, 1024);
    warm(1, 3'h1, 64);
    bus(0, 8'h14, 0, 4'hF);
    chk("irq status", 1, rdata);
    chk("irq masked", 0, irq);
    bus(1, 8'h18, 1, 4'hF);
    repeat (2) @(posedge clk);
    chk("irq on", 1, irq);
    bus(1, 8'h14, 1, 4'hF);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
    bus(1, 8'h04, 32'h00000304, 4'hF);
    repeat (3) @(posedge clk);
    chk("pll run", 1, pll_run);
    bus(0, 8'h04, 0, 4'hF);
    chk("osc readback", 32'h00000304, rdata);
    chk("osc enables", 3, {low_osc_enable, high_osc_enable});
    bus(1, 8'h04, 0, 4'hF);
    repeat (3) @(posedge clk);
    chk("osc all off", 0, {low_osc_enable, high_osc_enable, pll_run});
    for (i = 0; i < 5; i = i + 1) begin
      bus(1, 8'h08, i, 4'hF);
      repeat (3) @(posedge clk);
      chk("power mode", (i > 0 && i < 4) ? i : 0, low_power_mode);
    end
    results;
  end
endmodule // tb
